//--- hw/gated_timer_pkg.sv
`default_nettype none
package gated_timer_pkg;
    // Register offsets, as printed (byte addresses of the 8-bit register file)
    localparam logic [11:0] GATE_CONTROL_OFS    = 12'h0f9a;
    localparam logic [11:0] COUNTER_CONTROL_OFS = 12'h0fcd;
    localparam logic [11:0] COUNT_LOW_OFS       = 12'h0fce;
    localparam logic [11:0] COUNT_HIGH_OFS      = 12'h0fcf;
    localparam logic [11:0] STATUS_OFS          = 12'h0fd0;

    // Counter control field positions
    localparam int CC_ON     = 0;
    localparam int CC_WIDE   = 1;
    localparam int CC_NOSYNC = 2;
    localparam int CC_XTAL   = 3;
    localparam int CC_PS_LO  = 4;
    localparam int CC_CS_LO  = 6;

    // Gate control field positions
    localparam int GC_SS_LO  = 0;
    localparam int GC_VAL    = 2;
    localparam int GC_GO     = 3;
    localparam int GC_SPM    = 4;
    localparam int GC_TM     = 5;
    localparam int GC_POL    = 6;
    localparam int GC_GE     = 7;

    // Status register bit positions
    localparam int ST_OVF    = 0;
    localparam int ST_GDONE  = 1;
    localparam int ST_SOSC   = 2;

    // Reset values
    localparam logic [7:0] COUNTER_CONTROL_RST = 8'h00;
    localparam logic [7:0] GATE_CONTROL_RST    = 8'h00;

    // Clock source encodings
    localparam logic [1:0] CS_INSTR = 2'b00;
    localparam logic [1:0] CS_SYS   = 2'b01;
    localparam logic [1:0] CS_EXT   = 2'b10;

    // Gate source encodings
    localparam logic [1:0] GS_PIN   = 2'b00;
    localparam logic [1:0] GS_MATCH = 2'b01;
    localparam logic [1:0] GS_CMP1  = 2'b10;
    localparam logic [1:0] GS_CMP2  = 2'b11;

    // Instruction cycle is four system clocks
    localparam int INSTR_DIV = 4;

    // Register bus request
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;

    // Raw gate sources
    typedef struct packed {
        logic pin;
        logic periodMatch;
        logic cmp1;
        logic cmp2;
    } gate_src_t;

    // Single-pulse acquisition states
    typedef enum logic [1:0] {
        SP_IDLE,
        SP_ARMED,
        SP_COUNTING
    } sp_state_t;
endpackage
`default_nettype wire

//--- hw/gated_timer.sv
`default_nettype none
// Behaviour
// - Gate enable ignored while off; when on, set means gate decides counting.
// - Polarity one counts on high gate, zero counts on low gate.
// - Toggle mode routes gate through flip-flop; otherwise flip-flop held clear.
// - Single-pulse mode puts acquisition logic in control of the gate.
// - Acquisition go bit reads one while armed, zero when done or idle.
// - Clearing single-pulse mode clears the go bit.
// - Gate level status shows the applied gate, regardless of gate enable.
// - Gate source: pin, period match, comparator one, comparator two.
// - Sixteen-bit up counter in byte pair; internal source counts per cycle.
// - External source counts rising edges, always synchronised whatever the no-sync bit.
// - While counter on, crystal pins are inputs and read back zero.
// - Clock source: system, system/4, external pin, or crystal.
// - Counter mode needs a falling edge before first counted rising edge.
// - Wide mode: low byte read copies live high byte into buffer.
// - Wide mode: high write loads buffer; low write loads both bytes.
// - High byte write keeps prescaler; low byte write clears it.
// - Crystal enable starts the oscillator, kept running in low power.
// - Secondary oscillator running flag set while crystal enabled and clocking the system.
// - Armed acquisition counts from next gate edge, ends on trailing edge.
// - Period-match gate source is a one instruction cycle high pulse.
// - Counter rolls from maximum to zero and latches overflow flag.
// - Prescaler divides by one, two, four or eight.
module gated_timer
    import gated_timer_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input  wire logic       mclk,
    input  wire logic       rst_b,
    input  wire bus_req_t   busReq,
    output logic [7:0]      rdata,
    input  wire gate_src_t  gateSrc,
    input  wire logic       extCountIn,
    input  wire logic       crystalIn,
    input  wire logic       sysClkFromCrystal,
    input  wire logic [1:0] pinDirCtl,
    input  wire logic [1:0] pinOutCtl,
    output logic [1:0]      pinOut,
    output logic [1:0]      pinOutEn,
    output logic [1:0]      pinReadback,
    output logic            crystalPowerUp,
    output logic            overflowFlag,
    output logic            gateDoneFlag
);
    // Control registers and counter state
    logic [7:0]       ctrl_r;
    logic [1:0]       gateSel_r;
    logic             gateEn_r, gatePol_r, gateTm_r, gateSpm_r;
    logic [CNT_W-1:0] count_r, count_nxt;
    logic [7:0]       highBuf_r;
    logic [2:0]       presc_r, presc_nxt;
    logic [1:0]       instrDiv_r;
    logic             toggle_r;
    logic             gateSeen_r;
    logic             armed_r;
    logic             fallSeen_r;
    logic             ovf_r, gdone_r;
    logic             oscRun_r;
    logic [7:0]       rdata_r;
    sp_state_t        spState_r, spState_nxt;

    // Two-flop synchronisers for pins and crossing sources
    logic [3:0] sync1_r, sync2_r;
    logic [2:0] pinSync1_r, pinSync2_r;
    logic       extLast_r;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_r    <= 4'h0;
            sync2_r    <= 4'h0;
            pinSync1_r <= 3'h0;
            pinSync2_r <= 3'h0;
        end else begin
            sync1_r    <= gateSrc;
            sync2_r    <= sync1_r;
            pinSync1_r <= {extCountIn, crystalIn, sysClkFromCrystal};
            pinSync2_r <= pinSync1_r;
        end
    end

    // Named views of synchronised inputs
    gate_src_t gs;
    wire extCnt   = pinSync2_r[2];
    wire xtalCnt  = pinSync2_r[1];
    wire sysXtal  = pinSync2_r[0];
    assign gs = gate_src_t'(sync2_r);

    // Control fields
    wire       counterOn = ctrl_r[CC_ON];
    wire       wideMode  = ctrl_r[CC_WIDE];
    wire       xtalEn    = ctrl_r[CC_XTAL];
    wire [1:0] psSel     = ctrl_r[CC_PS_LO +: 2];
    wire [1:0] csSel     = ctrl_r[CC_CS_LO +: 2];

    // Bus decode
    wire wrGate = busReq.wr && busReq.addr == GATE_CONTROL_OFS;
    wire wrCtrl = busReq.wr && busReq.addr == COUNTER_CONTROL_OFS;
    wire wrLow  = busReq.wr && busReq.addr == COUNT_LOW_OFS;
    wire wrHigh = busReq.wr && busReq.addr == COUNT_HIGH_OFS;
    wire wrStat = busReq.wr && busReq.addr == STATUS_OFS;
    wire rdLow  = busReq.rd && busReq.addr == COUNT_LOW_OFS;

    // Instruction-cycle enable from a divide-by-four counter
    wire instrTick = instrDiv_r == 2'(INSTR_DIV - 1);

    // Raw gate source mux; period match is a one-cycle pulse from outside
    logic srcSel;
    always_comb begin
        case (gateSel_r)
            GS_PIN:   srcSel = gs.pin;
            GS_MATCH: srcSel = gs.periodMatch;
            GS_CMP1:  srcSel = gs.cmp1;
            GS_CMP2:  srcSel = gs.cmp2;
            default:  srcSel = gs.pin;
        endcase
    end

    // Polarity folds into the gate before the toggle stage
    wire polGate  = gatePol_r ? srcSel : ~srcSel;
    wire polRise  = polGate && !gateSeen_r;
    wire toggled  = gateTm_r ? toggle_r : polGate;
    wire tgRise   = gateTm_r ? polRise && !toggle_r : polRise;
    wire tgFall   = gateTm_r ? polRise && toggle_r
                             : !polGate && gateSeen_r;

    // Single-pulse stage: counts only between the armed edge pair
    always_comb begin
        spState_nxt = spState_r;
        case (spState_r)
            SP_IDLE:     if (armed_r) spState_nxt = SP_ARMED;
            // A go bit cleared by software abandons the armed wait
            SP_ARMED: begin
                if (!armed_r) spState_nxt = SP_IDLE;
                else if (tgRise) spState_nxt = SP_COUNTING;
            end
            SP_COUNTING: if (tgFall) spState_nxt = SP_IDLE;
            default:     spState_nxt = SP_IDLE;
        endcase
        if (!gateSpm_r) begin
            spState_nxt = SP_IDLE;
        end
    end
    wire spDone   = spState_r == SP_COUNTING && tgFall;
    wire effGate  = gateSpm_r ? (spState_r == SP_COUNTING) && toggled
                              : toggled;
    wire gateOk   = !gateEn_r || effGate;

    // Clock source edges; crystal chosen by crystal enable
    wire extLevel = xtalEn ? xtalCnt : extCnt;
    wire extRise  = extLevel && !extLast_r && fallSeen_r;
    logic srcTick;
    always_comb begin
        case (csSel)
            CS_SYS:   srcTick = 1'b1;
            CS_INSTR: srcTick = instrTick;
            CS_EXT:   srcTick = extRise;
            default:  srcTick = instrTick;
        endcase
    end

    // Prescaler: tick when low bits all set for the chosen ratio
    function automatic logic prescDone(input logic [2:0] c,
                                       input logic [1:0] s);
        logic [2:0] m;
        m = 3'((4'h1 << s) - 4'h1);
        prescDone = (c & m) == m;
    endfunction

    wire countTick = counterOn && gateOk && srcTick
                  && prescDone(presc_r, psSel);
    wire rollover  = countTick && &count_r;

    // Counter and prescaler next values; writes win over counting
    always_comb begin
        count_nxt = count_r;
        presc_nxt = presc_r;
        if (counterOn && gateOk && srcTick) begin
            presc_nxt = prescDone(presc_r, psSel) ? 3'h0 : presc_r + 3'h1;
        end
        if (countTick) begin
            count_nxt = count_r + CNT_W'(1);
        end
        if (wrLow) begin
            presc_nxt = 3'h0;
            count_nxt = {wideMode ? highBuf_r : count_r[15:8],
                         busReq.wdata};
        end else if (wrHigh && !wideMode) begin
            count_nxt = {busReq.wdata, count_r[7:0]};
        end
    end

    // Control registers
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r    <= COUNTER_CONTROL_RST;
            gateEn_r  <= GATE_CONTROL_RST[GC_GE];
            gatePol_r <= GATE_CONTROL_RST[GC_POL];
            gateTm_r  <= GATE_CONTROL_RST[GC_TM];
            gateSpm_r <= GATE_CONTROL_RST[GC_SPM];
            gateSel_r <= GATE_CONTROL_RST[GC_SS_LO +: 2];
        end else begin
            if (wrCtrl) ctrl_r <= busReq.wdata;
            if (wrGate) begin
                gateEn_r  <= busReq.wdata[GC_GE];
                gatePol_r <= busReq.wdata[GC_POL];
                gateTm_r  <= busReq.wdata[GC_TM];
                gateSpm_r <= busReq.wdata[GC_SPM];
                gateSel_r <= busReq.wdata[GC_SS_LO +: 2];
            end
        end
    end

    // Counter, prescaler, high-byte buffer
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            count_r    <= '0;
            presc_r    <= 3'h0;
            highBuf_r  <= 8'h00;
            instrDiv_r <= 2'h0;
        end else begin
            count_r    <= count_nxt;
            presc_r    <= presc_nxt;
            instrDiv_r <= instrDiv_r + 2'h1;
            if (rdLow && wideMode) highBuf_r <= count_r[15:8];
            else if (wrHigh) highBuf_r <= busReq.wdata;
        end
    end

    // Gate toggle, edge history and acquisition state
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            toggle_r   <= 1'b0;
            gateSeen_r <= 1'b1;  // Reset gate level, so no false edge
            spState_r  <= SP_IDLE;
            armed_r    <= 1'b0;
        end else begin
            gateSeen_r <= polGate;
            if (!gateTm_r) toggle_r <= 1'b0;
            else if (polRise) toggle_r <= ~toggle_r;
            spState_r <= spState_nxt;
            // Hardware clear on completion or leaving the mode
            if (!gateSpm_r || spDone) armed_r <= 1'b0;
            else if (wrGate) armed_r <= busReq.wdata[GC_GO]
                                        && busReq.wdata[GC_SPM];
        end
    end

    // External edge qualification; re-armed by writes and disable
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            extLast_r  <= 1'b1;
            fallSeen_r <= 1'b0;
        end else begin
            extLast_r <= extLevel;
            if (!counterOn || wrLow || wrHigh) fallSeen_r <= 1'b0;
            else if (!extLevel && extLast_r) fallSeen_r <= 1'b1;
        end
    end

    // Status flags; overflow and done are sticky, a hardware set beats a software clear
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ovf_r    <= 1'b0;
            gdone_r  <= 1'b0;
            oscRun_r <= 1'b0;
        end else begin
            oscRun_r <= sysXtal && xtalEn;
            if (rollover) ovf_r <= 1'b1;
            else if (wrStat && !busReq.wdata[ST_OVF]) ovf_r <= 1'b0;
            if (spDone) gdone_r <= 1'b1;
            else if (wrStat && !busReq.wdata[ST_GDONE]) gdone_r <= 1'b0;
        end
    end

    // Read mux; wide mode shows the buffer at the high address
    logic [7:0] rdMux;
    always_comb begin
        case (busReq.addr)
            GATE_CONTROL_OFS:    rdMux = {gateEn_r, gatePol_r, gateTm_r,
                                          gateSpm_r, armed_r, effGate,
                                          gateSel_r};
            COUNTER_CONTROL_OFS: rdMux = ctrl_r;
            COUNT_LOW_OFS:       rdMux = count_r[7:0];
            COUNT_HIGH_OFS:      rdMux = wideMode ? highBuf_r
                                                  : count_r[15:8];
            STATUS_OFS:          rdMux = {5'h00, oscRun_r, gdone_r, ovf_r};
            default:             rdMux = 8'h00;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) rdata_r <= 8'h00;
        else        rdata_r <= busReq.rd ? rdMux : 8'h00;
    end

    // Pin control; enabled counter forces both pins to inputs
    assign pinOut         = pinOutCtl;
    assign pinOutEn       = counterOn ? 2'b00 : ~pinDirCtl;
    assign pinReadback    = counterOn ? 2'b00
                                      : {pinSync2_r[1], pinSync2_r[2]};
    assign crystalPowerUp = xtalEn;
    assign rdata          = rdata_r;
    assign overflowFlag   = ovf_r;
    assign gateDoneFlag   = gdone_r;
endmodule
`default_nettype wire

//--- test/gated_timer_asserts.sv
`default_nettype none
module gated_timer_asserts
    import gated_timer_pkg::*;
(
    input wire logic       mclk,
    input wire logic       rst_b,
    input wire bus_req_t   busReq,
    input wire logic [7:0] rdata,
    input wire logic [1:0] pinDirCtl,
    input wire logic [1:0] pinOutCtl,
    input wire logic [1:0] pinOut,
    input wire logic [1:0] pinOutEn,
    input wire logic [1:0] pinReadback,
    input wire logic       crystalPowerUp,
    input wire logic       overflowFlag,
    input wire logic       gateDoneFlag
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ctl_r;
    // Software accesses that the checks depend on
    wire logic ctlWr = busReq.wr && busReq.addr == COUNTER_CONTROL_OFS;
    wire logic stWr  = busReq.wr && busReq.addr == STATUS_OFS;
    wire logic mapped = busReq.addr inside {GATE_CONTROL_OFS,
        COUNTER_CONTROL_OFS, COUNT_LOW_OFS, COUNT_HIGH_OFS, STATUS_OFS};
    // Shadow of counter control, so pin checks need no internal probe
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctl_r <= COUNTER_CONTROL_RST;
        end else if (ctlWr) begin
            ctl_r <= busReq.wdata;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    chk_read_idle: assert property (!$past(busReq.rd) |-> rdata == 8'h00)
        else $error("read data not zero outside its slot");
    chk_unmapped_zero: assert property
        ($past(busReq.rd) && !$past(mapped) |-> rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_ctl_readback: assert property ($past(busReq.rd) &&
        $past(busReq.addr) == COUNTER_CONTROL_OFS |-> rdata == $past(ctl_r))
        else $error("counter control readback wrong");
    chk_pins_forced: assert property (ctl_r[CC_ON] |->
        pinOutEn == 2'b00 && pinReadback == 2'b00)
        else $error("pins not forced to inputs while on");
    chk_pins_free: assert property (!ctl_r[CC_ON] |-> pinOutEn == ~pinDirCtl)
        else $error("pin enables ignore direction while off");
    chk_pin_value: assert property (pinOut == pinOutCtl)
        else $error("pin output value wrong");
    chk_xtal_power: assert property (crystalPowerUp == ctl_r[CC_XTAL])
        else $error("crystal power-up mismatch");
    chk_ovf_hold: assert property (overflowFlag &&
        !(stWr && !busReq.wdata[ST_OVF]) |=> overflowFlag)
        else $error("overflow flag dropped without clear");
    chk_done_hold: assert property (gateDoneFlag &&
        !(stWr && !busReq.wdata[ST_GDONE]) |=> gateDoneFlag)
        else $error("gate done flag dropped without clear");
    chk_ovf_cause: assert property ($rose(overflowFlag) |->
        $past(ctl_r[CC_ON]) || $past(ctl_r[CC_ON], 2))
        else $error("overflow while counter off");
    // Main scenarios reached
    cover property (ctlWr && busReq.wdata[CC_ON]);
    cover property ($rose(overflowFlag));
    cover property ($rose(gateDoneFlag));
endmodule
bind gated_timer gated_timer_asserts chk_u (
    .mclk(mclk), .rst_b(rst_b), .busReq(busReq), .rdata(rdata),
    .pinDirCtl(pinDirCtl), .pinOutCtl(pinOutCtl), .pinOut(pinOut),
    .pinOutEn(pinOutEn), .pinReadback(pinReadback),
    .crystalPowerUp(crystalPowerUp), .overflowFlag(overflowFlag),
    .gateDoneFlag(gateDoneFlag)
);
`default_nettype wire

//--- test/gated_timer_far_end.sv
`default_nettype none
module gated_timer_far_end (
    input  wire logic mclk,
    input  wire logic powerUp,
    output logic      extCount,
    output logic      gatePin,
    output logic      crystal
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int STARTUP = 40;
    int unsigned warm = 0;
    initial begin
        extCount = 1'b0;
        gatePin = 1'b0;
    end
    // Crystal stands still until powered and warmed, then runs slowly
    always @(posedge mclk) begin
        warm <= powerUp ? warm + 1 : 0;
    end
    assign crystal = powerUp && warm > STARTUP && warm[3];
    // Whole count pulses, each level held four cycles, idle low
    task automatic pulses(input int n);
        repeat (n) begin
            repeat (4) @(posedge mclk);
            extCount <= 1'b1;
            repeat (4) @(posedge mclk);
            extCount <= 1'b0;
        end
    endtask
    task automatic gate(input logic l);
        @(posedge mclk);
        gatePin <= l;
    endtask
endmodule
`default_nettype wire

//--- test/tb_gated_timer.sv
`default_nettype none
module tb_gated_timer import gated_timer_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic       mclk = 1'b0;
    logic       rst_b = 1'b0;
    bus_req_t   busReq = '0;
    logic [2:0] oth = 3'b000;
    logic       sysXtal = 1'b0;
    logic [7:0] rdata, v;
    logic [1:0] pinOutEn, pinReadback;
    logic       xtalUp, ovf, done, ext, gPin, xtal;
    int         failCount = 0;
    int         numChecks = 0;
    always #2 mclk = ~mclk;
    gated_timer dut_u (.mclk(mclk), .rst_b(rst_b), .busReq(busReq),
        .rdata(rdata), .gateSrc({gPin, oth}), .extCountIn(ext),
        .crystalIn(xtal), .sysClkFromCrystal(sysXtal), .pinDirCtl(2'b01),
        .pinOutCtl(2'b10), .pinOut(), .pinOutEn(pinOutEn),
        .pinReadback(pinReadback), .crystalPowerUp(xtalUp),
        .overflowFlag(ovf), .gateDoneFlag(done));
    gated_timer_far_end far_u (.mclk(mclk), .powerUp(xtalUp),
        .extCount(ext), .gatePin(gPin), .crystal(xtal));
    // Bus accesses leave one idle cycle so no strobe is assigned twice
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        busReq <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk);
        busReq <= '0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        busReq <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge mclk);
        busReq <= '0;
        #1 d = rdata;
        @(posedge mclk);
    endtask
    task automatic chk(input logic [7:0] got, exp, input int tol = 0);
        numChecks++;
        if ((got ^ got) !== 8'h00 || got > exp + tol || got + tol < exp) begin
            failCount++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Clear count, run for n cycles, stop, fetch low byte
    task automatic run(input logic [7:0] ctl, input int n);
        wr(COUNT_HIGH_OFS, 8'h00);
        wr(COUNT_LOW_OFS, 8'h00);
        wr(COUNTER_CONTROL_OFS, ctl);
        repeat (n) @(posedge mclk);
        wr(COUNTER_CONTROL_OFS, ctl & 8'hfe);
        rd(COUNT_LOW_OFS, v);
    endtask
    // Selected gate source to level l, every other source opposite
    task automatic drive_src(input logic [1:0] s, input logic l);
        far_u.gate(s == 2'd0 ? l : ~l);
        oth <= {3{~l}} ^ ((s == 2'd0) ? 3'b000 : (3'b100 >> (s - 2'd1)));
        repeat (4) @(posedge mclk);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", numChecks, failCount);
        if (failCount == 0 && numChecks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Watchdog against a hung run
    initial begin
        repeat (20000) @(posedge mclk);
        failCount++;
        end_of_test();
    end
    initial begin
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        rd(COUNTER_CONTROL_OFS, v);
        chk(v, COUNTER_CONTROL_RST);
        rd(GATE_CONTROL_OFS, v);
        chk(v & 8'hfb, GATE_CONTROL_RST);
        rd(12'h0f9b, v);
        chk(v, 8'h00);
        $display("reset test done");
        wr(GATE_CONTROL_OFS, 8'h00);
        for (int p = 0; p < 4; p++) begin
            run({CS_SYS, p[1:0], 4'h1}, 62);
            chk(v, 8'd64 >> p, 1);
        end
        run({CS_INSTR, 6'h01}, 62);
        chk(v, 8'd16, 1);
        $display("clock test done");
        wr(COUNT_HIGH_OFS, 8'hab);
        wr(COUNTER_CONTROL_OFS, 8'h02);
        wr(COUNT_HIGH_OFS, 8'h12);
        rd(COUNT_LOW_OFS, v);
        rd(COUNT_HIGH_OFS, v);
        chk(v, 8'hab);
        wr(COUNT_HIGH_OFS, 8'h12);
        wr(COUNT_LOW_OFS, 8'h34);
        wr(COUNTER_CONTROL_OFS, 8'h00);
        rd(COUNT_LOW_OFS, v);
        chk(v, 8'h34);
        rd(COUNT_HIGH_OFS, v);
        chk(v, 8'h12);
        wr(COUNTER_CONTROL_OFS, 8'h02);
        wr(COUNT_HIGH_OFS, 8'hff);
        wr(COUNT_LOW_OFS, 8'hfe);
        wr(COUNTER_CONTROL_OFS, 8'h43);
        repeat (4) @(posedge mclk);
        wr(COUNTER_CONTROL_OFS, 8'h42);
        chk({7'h0, ovf}, 8'h01);
        rd(COUNT_LOW_OFS, v);
        chk(v, 8'h04, 1);
        rd(COUNT_HIGH_OFS, v);
        chk(v, 8'h00);
        wr(STATUS_OFS, 8'h00);
        chk({7'h0, ovf}, 8'h00);
        $display("wide test done");
        for (int p = 0; p < 2; p++) begin
            for (int s = 0; s < 4; s++) begin
                wr(GATE_CONTROL_OFS, {1'b0, p[0], 4'h0, s[1:0]});
                for (int l = 0; l < 2; l++) begin
                    drive_src(s[1:0], l[0]);
                    rd(GATE_CONTROL_OFS, v);
                    chk({7'h0, v[GC_VAL]}, {7'h0, l[0] ~^ p[0]});
                end
            end
        end
        drive_src(2'd0, 1'b0);
        wr(GATE_CONTROL_OFS, 8'hc0);
        run({CS_SYS, 6'h01}, 30);
        chk(v, 8'h00);
        wr(GATE_CONTROL_OFS, 8'h80);
        run({CS_SYS, 6'h01}, 30);
        chk(v, 8'd32, 1);
        wr(GATE_CONTROL_OFS, 8'h40);
        run({CS_SYS, 6'h01}, 30);
        chk(v, 8'd32, 1);
        $display("gate test done");
        wr(GATE_CONTROL_OFS, 8'h60);
        for (int k = 0; k < 2; k++) begin
            drive_src(2'd0, ~k[0]);
            rd(GATE_CONTROL_OFS, v);
            chk({7'h0, v[GC_VAL]}, 8'h01);
        end
        wr(GATE_CONTROL_OFS, 8'h40);
        wr(GATE_CONTROL_OFS, 8'h60);
        rd(GATE_CONTROL_OFS, v);
        chk({7'h0, v[GC_VAL]}, 8'h00);
        wr(GATE_CONTROL_OFS, 8'hd0);
        wr(GATE_CONTROL_OFS, 8'hd8);
        rd(GATE_CONTROL_OFS, v);
        chk({7'h0, v[GC_GO]}, 8'h01);
        wr(COUNT_LOW_OFS, 8'h00);
        wr(COUNTER_CONTROL_OFS, 8'h41);
        repeat (2) begin
            far_u.gate(1'b1);
            repeat (8) @(posedge mclk);
            far_u.gate(1'b0);
            repeat (6) @(posedge mclk);
        end
        wr(COUNTER_CONTROL_OFS, 8'h40);
        rd(COUNT_LOW_OFS, v);
        chk(v, 8'd9, 1);
        rd(GATE_CONTROL_OFS, v);
        chk({7'h0, v[GC_GO]}, 8'h00);
        chk({7'h0, done}, 8'h01);
        wr(GATE_CONTROL_OFS, 8'hd8);
        wr(GATE_CONTROL_OFS, 8'hc8);
        rd(GATE_CONTROL_OFS, v);
        chk({7'h0, v[GC_GO]}, 8'h00);
        wr(GATE_CONTROL_OFS, 8'h00);
        wr(COUNT_LOW_OFS, 8'h00);
        wr(COUNTER_CONTROL_OFS, 8'h81);
        chk({4'h0, pinOutEn, pinReadback}, 8'h00);
        far_u.pulses(5);
        wr(COUNTER_CONTROL_OFS, 8'h80);
        chk({6'h00, pinOutEn}, 8'h02);
        rd(COUNT_LOW_OFS, v);
        chk(v, 8'd4);
        $display("pulse test done");
        wr(COUNTER_CONTROL_OFS, 8'h08);
        chk({7'h0, xtalUp}, 8'h01);
        sysXtal <= 1'b1;
        repeat (50) @(posedge mclk);
        rd(STATUS_OFS, v);
        chk({7'h0, v[ST_SOSC]}, 8'h01);
        run(8'h89, 126);
        chk(v, 8'd8, 1);
        wr(COUNTER_CONTROL_OFS, 8'h00);
        rd(STATUS_OFS, v);
        chk({7'h0, v[ST_SOSC]}, 8'h00);
        $display("crystal test done");
        end_of_test();
    end
endmodule
`default_nettype wire
